/* File: iscr_pkg.sv */
package iscr_pkg;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] IDX_EXC_GAIN   = 8'h00;
	localparam logic [7:0] IDX_AMP_GAIN   = 8'h01;
	localparam logic [7:0] IDX_DIG_CTRL   = 8'h03;
	localparam logic [7:0] IDX_COIL_STAT  = 8'h04;
	localparam logic [7:0] IDX_IRQ_STAT   = 8'h08;
	localparam logic [7:0] IDX_IRQ_CLR    = 8'h09;
	localparam logic [7:0] IDX_IRQ_EN     = 8'h0A;
	localparam logic [7:0] IDX_COARSE_SEL = 8'h10;
	// field positions
	localparam int BIT_EXTRP_DIS  = 15;
	localparam int BIT_COIL_START = 13;
	localparam int BIT_TURN_CLR   = 11;
	localparam int BIT_COIL_FLAG  = 13;
	localparam int AMP_COARSE_LSB = 8;
	localparam int AMP_FINE_LSB   = 0;
	// irq status bit positions
	localparam int IRQ_COIL_DONE  = 0;
	localparam int IRQ_COIL_OPEN  = 1;
	localparam int IRQ_GAIN_UPD   = 2;
	localparam int IRQ_W          = 3;
	localparam logic [15:0] RST_VAL = 16'h0000;
	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;

	typedef enum {ISCR_IDLE, ISCR_BUSY} iscr_coil_st_t;

	// gain readbacks from the control loops
	typedef struct packed {
		logic       valid;
		logic [7:0] exc_drive;
		logic [5:0] coarse_gain;
		logic [5:0] fine_gain;
	} iscr_gain_t;

	// routing of one coarse rectifier
	typedef struct packed {
		logic [2:0] pos_pin;
		logic [2:0] neg_pin;
		logic       neg_dc;
	} iscr_route_t;

	typedef struct packed {
		logic                  dp_pend;
		logic                  dp_write;
		logic [7:0]            dp_idx;
		logic [31:0]           rdata;
		logic [7:0]            exc_drive_code;
		logic [5:0]            coarse_amp_gain_code;
		logic [5:0]            fine_amp_gain_code;
		logic                  angle_extrapolation_disable;
		logic                  coil_check_start;
		logic                  turn_clear_pulse;
		logic                  coil_unconnected_flag;
		logic [15:0]           coarse_sel;
		logic [IRQ_W-1:0]      irq_stat;
		logic [IRQ_W-1:0]      irq_en;
		iscr_coil_st_t         coil_st;
	} iscr_state_t;
endpackage

/* File: iscr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - excitation drive code readable, loop-updated byte
// - drive code: top bits pick current range
// - amplifier gains readable, loop-updated
// - coarse gain 13:8, fine gain 5:0
// - gain code maps to ten times 1.189^code
// - bit 15 halts extrapolation during gain updates
// - bit 13 starts coil check, self-clears
// - bit 11 clears turn counter, self-clears
// - status bit 13 flags unconnected coil
// - coarse routing: eight two-bit selectors
// - equal selectors tie negative input to DC
// - selector picks pin 0-3 or 4-7
module iscr_regs
	import iscr_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire iscr_gain_t         gain_upd,
	input  wire logic               gain_updating,
	input  wire logic               coil_check_done,
	input  wire logic               coil_check_open,
	input  wire logic               channel_select,
	output logic                    angle_extrapolation_disable,
	output logic                    extrapolation_hold,
	output logic                    coil_check_start,
	output logic                    coil_check_go,
	output logic                    turn_count_clear,
	output logic [7:0]              excitation_drive_code,
	output logic [1:0]              excitation_range,
	output logic [5:0]              excitation_step,
	output logic [5:0]              coarse_amp_gain_code,
	output logic [5:0]              fine_amp_gain_code,
	output wire iscr_route_t [3:0]  coarse_route,
	output logic                    irq
);
	iscr_state_t s_q;
	iscr_state_t s_d;
	logic        addr_ph;
	logic        wr_dp;
	logic [15:0] wd;

	// address phase accepted only when the bus is ready
	assign addr_ph = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign wr_dp   = s_q.dp_pend && s_q.dp_write;
	assign wd      = hwdata[15:0];

	// next-state: bus decode, self-clearing bits, gain capture, sticky events
	always_comb begin
		s_d = s_q;
		s_d.dp_pend = addr_ph;
		s_d.turn_clear_pulse = 1'b0;
		if (addr_ph) begin
			s_d.dp_write = hwrite;
			s_d.dp_idx   = haddr[9:2];
		end
		// control loops refresh the readbacks; software cannot write them
		if (gain_upd.valid) begin
			s_d.exc_drive_code       = gain_upd.exc_drive;
			s_d.coarse_amp_gain_code = gain_upd.coarse_gain;
			s_d.fine_amp_gain_code   = gain_upd.fine_gain;
		end
		// coil check machine: a restart write in the done cycle runs it again
		unique case (s_q.coil_st)
			ISCR_IDLE: begin
				if (s_q.coil_check_start) begin
					s_d.coil_st = ISCR_BUSY;
				end
			end
			ISCR_BUSY: begin
				if (coil_check_done) begin
					s_d.coil_st               = ISCR_IDLE;
					s_d.coil_check_start      = 1'b0;
					s_d.coil_unconnected_flag = coil_check_open;
				end
			end
		endcase
		if (wr_dp && s_q.dp_idx == IDX_DIG_CTRL) begin
			s_d.angle_extrapolation_disable = wd[BIT_EXTRP_DIS];
			if (wd[BIT_COIL_START]) begin
				s_d.coil_check_start = 1'b1;
			end
			s_d.turn_clear_pulse = wd[BIT_TURN_CLR];
		end
		if (wr_dp && s_q.dp_idx == IDX_COARSE_SEL) begin
			s_d.coarse_sel = wd;
		end
		if (wr_dp && s_q.dp_idx == IDX_IRQ_EN) begin
			s_d.irq_en = wd[IRQ_W-1:0];
		end
		if (wr_dp && s_q.dp_idx == IDX_IRQ_CLR) begin
			s_d.irq_stat = s_q.irq_stat & ~wd[IRQ_W-1:0];
		end
		// events set after the clear so a same-cycle event survives
		if (s_q.coil_st == ISCR_BUSY && coil_check_done) begin
			s_d.irq_stat[IRQ_COIL_DONE] = 1'b1;
			if (coil_check_open) begin
				s_d.irq_stat[IRQ_COIL_OPEN] = 1'b1;
			end
		end
		if (gain_upd.valid) begin
			s_d.irq_stat[IRQ_GAIN_UPD] = 1'b1;
		end
		// read data from next-state values, so a write just ahead is already seen
		if (addr_ph && !hwrite) begin
			unique case (haddr[9:2])
				IDX_EXC_GAIN:   s_d.rdata = {24'h00_0000, s_d.exc_drive_code};
				IDX_AMP_GAIN:   s_d.rdata = {18'h0_0000, s_d.coarse_amp_gain_code,
					2'b00, s_d.fine_amp_gain_code};
				IDX_DIG_CTRL:   s_d.rdata = {16'h0000,
					s_d.angle_extrapolation_disable, 1'b0, s_d.coil_check_start, 1'b0,
					s_d.turn_clear_pulse, 11'h000};
				IDX_COIL_STAT:  s_d.rdata = {16'h0000, 2'b00, s_d.coil_unconnected_flag,
					13'h0000};
				IDX_IRQ_STAT:   s_d.rdata = {29'h0000_0000, s_d.irq_stat};
				IDX_IRQ_EN:     s_d.rdata = {29'h0000_0000, s_d.irq_en};
				IDX_COARSE_SEL: s_d.rdata = {16'h0000, s_d.coarse_sel};
				default:        s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '{coil_st: ISCR_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// bus answers: never waits, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = s_q.rdata;

	assign angle_extrapolation_disable = s_q.angle_extrapolation_disable;
	// hold only while an update is under way and the feature is asked for
	assign extrapolation_hold = s_q.angle_extrapolation_disable && gain_updating;
	assign coil_check_start   = s_q.coil_check_start;
	assign coil_check_go      = s_q.coil_st == ISCR_BUSY;
	assign turn_count_clear   = s_q.turn_clear_pulse;
	assign excitation_drive_code = s_q.exc_drive_code;
	// range index and step n feed the current dac: range base + step*n
	assign excitation_range   = s_q.exc_drive_code[7:6];
	assign excitation_step    = s_q.exc_drive_code[5:0];
	// analog gain is 10*1.189^code; the code goes to the amp ladder unchanged
	assign coarse_amp_gain_code = s_q.coarse_amp_gain_code;
	assign fine_amp_gain_code   = s_q.fine_amp_gain_code;
	assign irq = |(s_q.irq_stat & s_q.irq_en);

	// per-rectifier pin decode: channel select adds four to the pin number
	generate
		for (genvar r = 0; r < 4; r++) begin : g_rect
			logic [1:0] pos_sel;
			logic [1:0] neg_sel;
			assign pos_sel = s_q.coarse_sel[4*r+3 -: 2];
			assign neg_sel = s_q.coarse_sel[4*r+1 -: 2];
			assign coarse_route[r].pos_pin = {channel_select, pos_sel};
			assign coarse_route[r].neg_pin = {channel_select, neg_sel};
			assign coarse_route[r].neg_dc  = pos_sel == neg_sel;
		end
	endgenerate

	// checks
	property p_turn_clear;
		@(posedge clk_sys) disable iff (rst)
		(wr_dp && s_q.dp_idx == IDX_DIG_CTRL && wd[BIT_TURN_CLR])
			|=> turn_count_clear ##1 !turn_count_clear;
	endproperty
	a_turn_clear: assert property (p_turn_clear) else $error("turn clear not one pulse");

	property p_coil_start;
		@(posedge clk_sys) disable iff (rst)
		(wr_dp && s_q.dp_idx == IDX_DIG_CTRL && wd[BIT_COIL_START] && !coil_check_go)
			|=> coil_check_start ##1 coil_check_go;
	endproperty
	a_coil_start: assert property (p_coil_start) else $error("coil check did not start");

	property p_coil_done;
		@(posedge clk_sys) disable iff (rst)
		(coil_check_go && coil_check_done && !(wr_dp && s_q.dp_idx == IDX_DIG_CTRL
			&& wd[BIT_COIL_START])) |=> !coil_check_start && !coil_check_go;
	endproperty
	a_coil_done: assert property (p_coil_done) else $error("run bit not cleared");

	property p_flag;
		@(posedge clk_sys) disable iff (rst)
		(coil_check_go && coil_check_done) |=> s_q.coil_unconnected_flag == $past(coil_check_open);
	endproperty
	a_flag: assert property (p_flag) else $error("open coil flag wrong");

	property p_neg_dc;
		@(posedge clk_sys) disable iff (rst)
		(s_q.coarse_sel[15:14] == s_q.coarse_sel[13:12]) |-> coarse_route[3].neg_dc;
	endproperty
	a_neg_dc: assert property (p_neg_dc) else $error("dc tie missing");

	property p_route;
		@(posedge clk_sys) disable iff (rst)
		channel_select |-> coarse_route[0].pos_pin == {1'b1, s_q.coarse_sel[3:2]};
	endproperty
	a_route: assert property (p_route) else $error("pin decode wrong");

	property p_gain;
		@(posedge clk_sys) disable iff (rst)
		gain_upd.valid |=> excitation_drive_code == $past(gain_upd.exc_drive)
			&& coarse_amp_gain_code == $past(gain_upd.coarse_gain);
	endproperty
	a_gain: assert property (p_gain) else $error("gain readback stale");

	property p_amp_rd;
		@(posedge clk_sys) disable iff (rst)
		(addr_ph && !hwrite && haddr[9:2] == IDX_AMP_GAIN)
			|=> hrdata[31:14] == 18'h0_0000 && hrdata[7:6] == 2'b00;
	endproperty
	a_amp_rd: assert property (p_amp_rd) else $error("reserved bits nonzero");

	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		(gain_updating && !angle_extrapolation_disable) |-> !extrapolation_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("hold without enable");

	// read answers: reserved bits zero, fields match the registers they show
	property p_exc_rd;
		@(posedge clk_sys) disable iff (rst)
		(addr_ph && !hwrite && haddr[9:2] == IDX_EXC_GAIN)
			|=> hrdata == {24'h00_0000, excitation_drive_code};
	endproperty
	a_exc_rd: assert property (p_exc_rd) else $error("drive code read wrong");

	property p_amp_val;
		@(posedge clk_sys) disable iff (rst)
		(addr_ph && !hwrite && haddr[9:2] == IDX_AMP_GAIN)
			|=> hrdata[13:8] == coarse_amp_gain_code
			&& hrdata[5:0] == fine_amp_gain_code;
	endproperty
	a_amp_val: assert property (p_amp_val) else $error("gain fields misplaced");

	property p_ctrl_rd;
		@(posedge clk_sys) disable iff (rst)
		(addr_ph && !hwrite && haddr[9:2] == IDX_DIG_CTRL)
			|=> hrdata == {16'h0000, angle_extrapolation_disable, 1'b0, coil_check_start,
				1'b0, turn_count_clear, 11'h000};
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");

	property p_stat_rd;
		@(posedge clk_sys) disable iff (rst)
		(addr_ph && !hwrite && haddr[9:2] == IDX_COIL_STAT)
			|=> hrdata == {18'h0_0000, s_q.coil_unconnected_flag, 13'h0000};
	endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

	property p_sel_rd;
		@(posedge clk_sys) disable iff (rst)
		(addr_ph && !hwrite && haddr[9:2] == IDX_COARSE_SEL)
			|=> hrdata == {16'h0000, s_q.coarse_sel};
	endproperty
	a_sel_rd: assert property (p_sel_rd) else $error("routing read wrong");

	// writes: routing keeps only the low half, the read-only drive code keeps its value
	property p_sel_wr;
		@(posedge clk_sys) disable iff (rst)
		(wr_dp && s_q.dp_idx == IDX_COARSE_SEL) |=> s_q.coarse_sel == $past(wd);
	endproperty
	a_sel_wr: assert property (p_sel_wr) else $error("routing write lost");

	property p_ro_wr;
		@(posedge clk_sys) disable iff (rst)
		(wr_dp && s_q.dp_idx == IDX_EXC_GAIN && !gain_upd.valid)
			|=> $stable(excitation_drive_code);
	endproperty
	a_ro_wr: assert property (p_ro_wr) else $error("read-only code written");

	property p_start_hold;
		@(posedge clk_sys) disable iff (rst)
		(coil_check_go && !coil_check_done) |=> coil_check_start;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("run bit dropped early");

	// completion event is sticky even against a clear in the same cycle
	property p_irq_set;
		@(posedge clk_sys) disable iff (rst)
		(coil_check_go && coil_check_done) |=> s_q.irq_stat[IRQ_COIL_DONE];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("done event not latched");

	property p_route_neg;
		@(posedge clk_sys) disable iff (rst)
		!channel_select |-> coarse_route[2].neg_pin == {1'b0, s_q.coarse_sel[9:8]};
	endproperty
	a_route_neg: assert property (p_route_neg) else $error("negative pin decode wrong");

	c_coil_run: cover property (@(posedge clk_sys) disable iff (rst)
		coil_check_go && coil_check_done && coil_check_open);
	c_turn: cover property (@(posedge clk_sys) disable iff (rst) turn_count_clear);
	c_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);
endmodule
`default_nettype wire

/* File: test_iscr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_iscr_regs
	import iscr_pkg::*;
;
	logic              clk_sys = 1'b0;
	logic              rst = 1'b1;
	logic              hsel = 1'b0, hwrite = 1'b0, gain_updating = 1'b0;
	logic              coil_check_done = 1'b0, coil_check_open = 1'b0, channel_select = 1'b0;
	logic [31:0]       haddr = '0, hwdata = '0, rd;
	logic [1:0]        htrans = 2'b00;
	logic [2:0]        hsize = 3'b010;
	iscr_gain_t        gain_upd = '0;
	wire logic         hready, hresp, ext_dis, ext_hold, ck_start, ck_go, turn_clr, irq;
	wire logic [31:0]  hrdata;
	wire logic [7:0]   exc_code;
	wire logic [1:0]   exc_range;
	wire logic [5:0]   exc_step, c_gain, f_gain;
	iscr_route_t [3:0] route;
	int                n_errors = 0, total_checks = 0, n_pulse = 0;

	iscr_regs uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .gain_upd(gain_upd), .gain_updating(gain_updating),
		.coil_check_done(coil_check_done), .coil_check_open(coil_check_open),
		.channel_select(channel_select), .angle_extrapolation_disable(ext_dis),
		.extrapolation_hold(ext_hold), .coil_check_start(ck_start), .coil_check_go(ck_go),
		.turn_count_clear(turn_clr), .excitation_drive_code(exc_code),
		.excitation_range(exc_range), .excitation_step(exc_step), .coarse_amp_gain_code(c_gain),
		.fine_amp_gain_code(f_gain), .coarse_route(route), .irq(irq));

	always #5 clk_sys = ~clk_sys;
	// counts clear pulses so a stuck-high or missing pulse both show
	always @(posedge clk_sys) if (turn_clr === 1'b1) n_pulse++;

	task automatic stop_test();
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// waits for hready at a rising edge, bounded so a hang ends the run
	task automatic wait_rdy();
		int i;
		i = 0;
		do begin @(posedge clk_sys); i++; end while (hready !== 1'b1 && i < 50);
		if (i >= 50) begin chk("hready", 32'h0000_0001, 32'h0000_0000); stop_test(); end
	endtask

	// one single word transfer; read data taken at the data phase edge
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
		wait_rdy();
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk("hresp", 32'h0000_0000, {31'b0, hresp});
	endtask

	task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask

	// reset values, unmapped read and writes aimed at read-only places
	task automatic t_reset_ro();
		rdchk("exc", 32'h0000_0000, 32'h0000_0000);
		rdchk("amp", 32'h0000_0004, 32'h0000_0000);
		rdchk("ctl", 32'h0000_000C, 32'h0000_0000);
		rdchk("sta", 32'h0000_0010, 32'h0000_0000);
		rdchk("sel", 32'h0000_0040, 32'h0000_0000);
		rdchk("unmapped", 32'h0000_003C, 32'h0000_0000);
		ahb(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
		ahb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
		rdchk("exc ro", 32'h0000_0000, 32'h0000_0000);
		rdchk("amp ro", 32'h0000_0004, 32'h0000_0000);
	endtask

	// one update per current range, gains walk across both fields
	task automatic t_gains();
		logic [7:0] codes[4];
		codes = '{8'h05, 8'h4A, 8'h8F, 8'hFF};
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			gain_upd <= '{1'b1, codes[k], 6'(k * 21), 6'(62 - k * 20)};
			@(posedge clk_sys);
			gain_upd.valid <= 1'b0;
			@(negedge clk_sys);
			chk("range", {30'b0, codes[k][7:6]}, {30'b0, exc_range});
			chk("step", {26'b0, codes[k][5:0]}, {26'b0, exc_step});
			chk("exc out", {24'b0, codes[k]}, {24'b0, exc_code});
			@(posedge clk_sys);
			rdchk("exc", 32'h0000_0000, {24'b0, codes[k]});
			rdchk("amp", 32'h0000_0004, {18'b0, 6'(k * 21), 2'b00, 6'(62 - k * 20)});
		end
		chk("gain out", {20'b0, 6'h3F, 6'h02}, {20'b0, c_gain, f_gain});
	endtask

	// reserved bits, turn clear pulse, extrapolation hold
	task automatic t_ctrl();
		ahb(1'b1, 32'h0000_000C, 32'hFFFF_57FF);
		rdchk("ctl rsv", 32'h0000_000C, 32'h0000_0000);
		ahb(1'b1, 32'h0000_000C, 32'h0000_8800);
		repeat (3) @(posedge clk_sys);
		chk("clr pulses", 32'h0000_0001, n_pulse);
		rdchk("ctl", 32'h0000_000C, 32'h0000_8000);
		gain_updating <= 1'b1;
		@(negedge clk_sys);
		chk("hold", 32'h0000_0003, {30'b0, ext_dis, ext_hold});
		@(posedge clk_sys);
		gain_updating <= 1'b0;
		@(negedge clk_sys);
		chk("hold off", 32'h0000_0002, {30'b0, ext_dis, ext_hold});
		@(posedge clk_sys);
	endtask

	// coil check run with an open coil, then the event interrupts
	task automatic t_coil_irq();
		int i;
		ahb(1'b1, 32'h0000_000C, 32'h0000_2000);
		i = 0;
		while (ck_go !== 1'b1 && i < 4) begin @(posedge clk_sys); i++; end
		chk("go", 32'h0000_0001, {31'b0, ck_go});
		rdchk("ctl run", 32'h0000_000C, 32'h0000_2000);
		coil_check_done <= 1'b1; coil_check_open <= 1'b1;
		@(posedge clk_sys);
		coil_check_done <= 1'b0; coil_check_open <= 1'b0;
		@(negedge clk_sys);
		chk("go end", 32'h0000_0000, {30'b0, ck_go, ck_start});
		@(posedge clk_sys);
		rdchk("ctl end", 32'h0000_000C, 32'h0000_0000);
		rdchk("sta", 32'h0000_0010, 32'h0000_2000);
		rdchk("irq st", 32'h0000_0020, 32'h0000_0007);
		chk("irq off", 32'h0000_0000, {31'b0, irq});
		ahb(1'b1, 32'h0000_0028, 32'h0000_0002);
		@(negedge clk_sys);
		chk("irq on", 32'h0000_0001, {31'b0, irq});
		@(posedge clk_sys);
		ahb(1'b1, 32'h0000_0024, 32'h0000_0002);
		@(negedge clk_sys);
		chk("irq clr", 32'h0000_0000, {31'b0, irq});
		@(posedge clk_sys);
		rdchk("irq st2", 32'h0000_0020, 32'h0000_0005);
		rdchk("irq wo", 32'h0000_0024, 32'h0000_0000);
		rdchk("sta kept", 32'h0000_0010, 32'h0000_2000);
	endtask

	// routing under both channel selects; rectifier 3 has equal selectors
	task automatic t_route();
		logic [15:0] v;
		logic [1:0]  p, n;
		v = 16'h5CB2;
		ahb(1'b1, 32'h0000_0040, {16'hFFFF, v});
		rdchk("sel", 32'h0000_0040, {16'h0000, v});
		for (int cs = 0; cs < 2; cs++) begin
			channel_select <= cs[0];
			@(negedge clk_sys);
			for (int r = 0; r < 4; r++) begin
				p = v[4*r+2 +: 2];
				n = v[4*r +: 2];
				chk("pos", {29'b0, cs[0], p}, {29'b0, route[r].pos_pin});
				chk("dc", {31'b0, n == p}, {31'b0, route[r].neg_dc});
				if (n != p) chk("neg", {29'b0, cs[0], n}, {29'b0, route[r].neg_pin});
			end
			@(posedge clk_sys);
		end
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset_ro();
		t_gains();
		t_ctrl();
		t_coil_irq();
		t_route();
		stop_test();
	end
endmodule
`default_nettype wire
